//--- design/lmt_timer.sv
// Purpose: Long on-delay timer and multi-output timer behind Wishbone.
// Assumes: Software writes a command word once per program scan to evaluate.
// Notes: Elapsed 100 ms ticks are banked and applied one step per clock.
//
// Overview of operation
// - Long timer counts down in 0.1 s units with 32-bit eight-digit values.
// - Evaluated with input off, long present value reloads and flag clears.
// - Input rising edge loads and starts countdown; flag set at zero.
// - After timeout value and flag hold until re-trigger or nonzero write.
// - Decimal mode raises error flag on non-decimal present or set value.
// - Present value moves only at evaluation, in 100 ms steps.
// - Completion flag refreshed only at evaluation, possibly one scan late.
// - Interlocked evaluation reloads present value and clears flag.
// - Skipped evaluation leaves long present value unchanged.
// - Writing the flag word alters only the flag, never the value.
// - Long timer state lives only in its own words, no shared slot.
// - Multi timer counts up, one value against eight set values.
// - Control word: flags bits 0-7, reset bit 8, pause bit 9.
// - Execution on, reset and pause off: present value increments.
// - Pause on, reset off: value and flags hold; banked time is dropped.
// - Each counting evaluation sets flags whose set value is not above present, up to the first zero set value.
// - Present value at maximum wraps to zero and clears all flags.
// - Reset bit forces zero value and clears flags, paused or not.
// - Reset and pause bits act only with execution condition on.
// - Multi present value is one word, decimal 0-9999 or binary 0-65535.
`timescale 1ns/1ps
`default_nettype none
module lmt_timer
   import lmt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   localparam logic [21:0] TC_END = 22'(TICK_CYCLES - 1);

   // True when every nibble of v is a decimal digit
   function automatic logic bcd_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int d = 0; d < 8; d++) begin
         if (v[4*d +: 4] > DIGIT_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : bcd_ok

   // One unit up or down, decimal or binary; caller guards the ends
   function automatic logic [31:0] step1(input logic [31:0] v, input logic up,
                                          input logic bcd);
      logic [31:0] r;
      logic cy;
      r = v;
      cy = 1'b1;
      if (!bcd) begin
         r = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
      end else begin
         for (int d = 0; d < 8; d++) begin
            if (cy) begin
               if (up) begin
                  cy = (v[4*d +: 4] == DIGIT_MAX);
                  r[4*d +: 4] = cy ? 4'h0 : v[4*d +: 4] + 4'h1;
               end else begin
                  cy = (v[4*d +: 4] == 4'h0);
                  r[4*d +: 4] = cy ? DIGIT_MAX : v[4*d +: 4] - 4'h1;
               end
            end
         end
      end
      return r;
   endfunction : step1

   // Byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : merge16

   lmt_state_t s_r;
   lmt_state_t s_nxt;
   logic req;
   logic wr;
   logic tick;
   logic [15:0] wd16;
   logic [15:0] mt_max;

   assign req = wb_cyc_i && wb_stb_i && !s_r.ack;
   assign wr = req && wb_we_i;
   assign tick = (s_r.tick_cnt == TC_END);
   assign wd16 = wb_dat_i[15:0];
   assign mt_max = s_r.mt_bcd ? MT_MAX_BCD : MT_MAX_BIN;
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;

   // Next-state logic: time base, evaluation engine, then bus access
   always_comb begin
      logic stop;
      stop = 1'b0;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      // Free-running 100 ms time base banked per timer, saturating
      s_nxt.tick_cnt = tick ? 22'h000000 : s_r.tick_cnt + 22'h000001;
      if (tick && s_r.lt_acc != ACC_MAX) begin
         s_nxt.lt_acc = s_r.lt_acc + 8'h01;
      end
      if (tick && s_r.mt_acc != ACC_MAX) begin
         s_nxt.mt_acc = s_r.mt_acc + 8'h01;
      end

      // Step engine, one 0.1 s unit per clock
      unique case (s_r.fsm)
         ST_IDLE: begin
            // Nothing moves between evaluations; only the banked time grows
         end
         ST_LT: begin
            if (s_r.lt_steps != 8'h00) begin
               s_nxt.lt_steps = s_r.lt_steps - 8'h01;
               if (s_r.lt_pv != 32'h0000_0000) begin
                  s_nxt.lt_pv = step1(s_r.lt_pv, 1'b0, s_r.lt_bcd);
               end
            end else begin
               // Flag only refreshed here, at the end of an evaluation
               s_nxt.lt_flag = (s_r.lt_pv == 32'h0000_0000);
               s_nxt.fsm = ST_IDLE;
            end
         end
         ST_MT: begin
            if (s_r.mt_steps != 8'h00) begin
               s_nxt.mt_steps = s_r.mt_steps - 8'h01;
               if (s_r.mt_pv == mt_max) begin
                  s_nxt.mt_pv = 16'h0000;
                  s_nxt.mt_ctrl[MT_NFLAG-1:0] = 8'h00;
               end else begin
                  s_nxt.mt_pv = 16'(step1({16'h0000, s_r.mt_pv}, 1'b1, s_r.mt_bcd));
               end
            end else begin
               // A zero set value ends the list; bad decimal ones are skipped
               for (int i = 0; i < MT_NFLAG; i++) begin
                  if (s_r.mt_sv[i] == 16'h0000) begin
                     stop = 1'b1;
                  end
                  if (!stop && !(s_r.mt_bcd && !bcd_ok({16'h0000, s_r.mt_sv[i]}))
                      && s_r.mt_sv[i] <= s_r.mt_pv) begin
                     s_nxt.mt_ctrl[i] = 1'b1;
                  end
               end
               s_nxt.fsm = ST_IDLE;
            end
         end
         default: begin
            s_nxt.fsm = ST_IDLE;
         end
      endcase

      // Bus access; software writes win over the engine in the same cycle
      if (req) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = 32'h0000_0000;
         unique case (wb_adr_i)
            A_LT_SV_LO: s_nxt.dat[15:0] = s_r.lt_sv[15:0];
            A_LT_SV_HI: s_nxt.dat[15:0] = s_r.lt_sv[31:16];
            A_LT_PV_LO: s_nxt.dat[15:0] = s_r.lt_pv[15:0];
            A_LT_PV_HI: s_nxt.dat[15:0] = s_r.lt_pv[31:16];
            A_LT_FLAG: s_nxt.dat[0] = s_r.lt_flag;
            A_LT_CMD: begin
               s_nxt.dat[LC_INPUT] = s_r.lt_in_prev;
               s_nxt.dat[LC_BCD] = s_r.lt_bcd;
               s_nxt.dat[ST_ERR] = s_r.lt_err;
               s_nxt.dat[ST_BUSY] = (s_r.fsm != ST_IDLE);
            end
            A_MT_CTRL: s_nxt.dat[9:0] = s_r.mt_ctrl;
            A_MT_PV: s_nxt.dat[15:0] = s_r.mt_pv;
            A_MT_CMD: begin
               s_nxt.dat[MC_BCD] = s_r.mt_bcd;
               s_nxt.dat[ST_ERR] = s_r.mt_err;
               s_nxt.dat[ST_BUSY] = (s_r.fsm != ST_IDLE);
            end
            default: begin
               if (wb_adr_i >= A_MT_SV0 && wb_adr_i <= A_MT_SV7
                   && wb_adr_i[1:0] == 2'b00) begin
                  s_nxt.dat[15:0] = s_r.mt_sv[wb_adr_i[4:2]];
               end
            end
         endcase
      end

      if (wr) begin
         unique case (wb_adr_i)
            A_LT_SV_LO: s_nxt.lt_sv[15:0] = merge16(s_r.lt_sv[15:0], wd16, wb_sel_i[1:0]);
            A_LT_SV_HI: s_nxt.lt_sv[31:16] = merge16(s_r.lt_sv[31:16], wd16, wb_sel_i[1:0]);
            // A nonzero value restarts timing at the next evaluation
            A_LT_PV_LO: s_nxt.lt_pv[15:0] = merge16(s_r.lt_pv[15:0], wd16, wb_sel_i[1:0]);
            A_LT_PV_HI: s_nxt.lt_pv[31:16] = merge16(s_r.lt_pv[31:16], wd16, wb_sel_i[1:0]);
            A_LT_FLAG: begin
               if (wb_sel_i[0]) begin
                  s_nxt.lt_flag = wb_dat_i[0];
               end
            end
            A_LT_CMD: begin
               // Evaluation of the long timer; ignored while busy
               if (wb_sel_i[0] && s_r.fsm == ST_IDLE) begin
                  s_nxt.lt_bcd = wb_dat_i[LC_BCD];
                  s_nxt.lt_acc = tick ? 8'h01 : 8'h00;
                  if (wb_dat_i[LC_BCD] && (!bcd_ok(s_r.lt_pv) || !bcd_ok(s_r.lt_sv))) begin
                     s_nxt.lt_err = 1'b1;
                  end else begin
                     s_nxt.lt_err = 1'b0;
                     if (wb_dat_i[LC_ILOCK] || !wb_dat_i[LC_INPUT]) begin
                        s_nxt.lt_pv = s_r.lt_sv;
                        s_nxt.lt_flag = 1'b0;
                        s_nxt.lt_in_prev = 1'b0;
                     end else begin
                        // Rising edge loads and starts with no banked time
                        if (!s_r.lt_in_prev) begin
                           s_nxt.lt_pv = s_r.lt_sv;
                           s_nxt.lt_steps = 8'h00;
                        end else begin
                           s_nxt.lt_steps = s_r.lt_acc;
                        end
                        s_nxt.lt_in_prev = 1'b1;
                        s_nxt.fsm = ST_LT;
                     end
                  end
               end
            end
            A_MT_CTRL: s_nxt.mt_ctrl = 10'(merge16({6'h00, s_r.mt_ctrl}, wd16, wb_sel_i[1:0]));
            A_MT_PV: s_nxt.mt_pv = merge16(s_r.mt_pv, wd16, wb_sel_i[1:0]);
            A_MT_CMD: begin
               // Without the execution condition nothing happens at all
               if (wb_sel_i[0] && wb_dat_i[MC_EXEC] && s_r.fsm == ST_IDLE) begin
                  s_nxt.mt_bcd = wb_dat_i[MC_BCD];
                  s_nxt.mt_err = wb_dat_i[MC_BCD] && !bcd_ok({16'h0000, s_r.mt_pv});
                  if (!s_nxt.mt_err) begin
                     s_nxt.mt_acc = tick ? 8'h01 : 8'h00;
                     if (s_r.mt_ctrl[MT_RST_BIT]) begin
                        s_nxt.mt_pv = 16'h0000;
                        s_nxt.mt_ctrl[MT_NFLAG-1:0] = 8'h00;
                     end else if (!s_r.mt_ctrl[MT_PAUSE_BIT]) begin
                        s_nxt.mt_steps = s_r.mt_acc;
                        s_nxt.fsm = ST_MT;
                     end
                     // Paused: banked time is dropped and the value holds
                  end
               end
            end
            default: begin
               if (wb_adr_i >= A_MT_SV0 && wb_adr_i <= A_MT_SV7
                   && wb_adr_i[1:0] == 2'b00) begin
                  s_nxt.mt_sv[wb_adr_i[4:2]] = merge16(s_r.mt_sv[wb_adr_i[4:2]], wd16,
                                                      wb_sel_i[1:0]);
               end
            end
         endcase
      end
   end

   // State register; every timer word lives here and in no shared area
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Evaluation requests as the engine takes them; a busy engine ignores them
   sequence lt_eval;
      wr && wb_adr_i == A_LT_CMD && wb_sel_i[0] && s_r.fsm == ST_IDLE;
   endsequence
   sequence mt_eval;
      wr && wb_adr_i == A_MT_CMD && wb_sel_i[0] && s_r.fsm == ST_IDLE
         && wb_dat_i[MC_EXEC] && !wb_dat_i[MC_BCD];
   endsequence
   // Binary-mode start of a fresh long timing run
   sequence lt_start;
      lt_eval ##0 (!wb_dat_i[LC_BCD] && wb_dat_i[LC_INPUT] && !wb_dat_i[LC_ILOCK]
         && !s_r.lt_in_prev);
   endsequence
   // Software forcing the long completion flag while the engine rests
   sequence lt_force;
      wr && wb_adr_i == A_LT_FLAG && wb_sel_i[0] && s_r.fsm == ST_IDLE;
   endsequence
   // Multi command with the execution condition off
   sequence mt_skip;
      wr && wb_adr_i == A_MT_CMD && wb_sel_i[0] && s_r.fsm == ST_IDLE
         && !wb_dat_i[MC_EXEC];
   endsequence

   // Long timer: reload, start, countdown and flag refresh
   AST_LT_OFF: assert property (lt_eval and (!wb_dat_i[LC_BCD] && !wb_dat_i[LC_INPUT])
      |=> s_r.lt_pv == $past(s_r.lt_sv) && !s_r.lt_flag)
      else $error("long timer not reloaded with input off");
   AST_LT_ILOCK: assert property (lt_eval and (!wb_dat_i[LC_BCD] && wb_dat_i[LC_ILOCK])
      |=> s_r.lt_pv == $past(s_r.lt_sv) && !s_r.lt_flag)
      else $error("long timer not reloaded when interlocked");
   AST_LT_START: assert property (lt_start
      |=> s_r.lt_pv == $past(s_r.lt_sv) && s_r.fsm == ST_LT)
      else $error("long timer did not start on input edge");
   AST_LT_DEC: assert property (s_r.fsm == ST_LT && s_r.lt_steps != 8'h00
      && s_r.lt_pv != 32'h0000_0000 && !s_r.lt_bcd && !wr
      |=> s_r.lt_pv == $past(s_r.lt_pv) - 32'h0000_0001)
      else $error("long timer step missed");
   // A timed-out value must not roll under zero while banked steps drain
   AST_LT_SAT: assert property (s_r.fsm == ST_LT && s_r.lt_pv == 32'h0000_0000 && !wr
      |=> s_r.lt_pv == 32'h0000_0000)
      else $error("long timer moved after timeout");
   AST_LT_DONE: assert property (s_r.fsm == ST_LT && s_r.lt_steps == 8'h00 && !wr
      |=> s_r.fsm == ST_IDLE && s_r.lt_flag == ($past(s_r.lt_pv) == 32'h0000_0000))
      else $error("long timer flag not refreshed");
   AST_LT_HOLD: assert property (s_r.fsm == ST_IDLE && !wr |=> $stable(s_r.lt_pv))
      else $error("long timer value moved without evaluation");
   AST_LT_FORCE: assert property (lt_force
      |=> s_r.lt_flag == $past(wb_dat_i[0]) && $stable(s_r.lt_pv))
      else $error("flag forcing disturbed the long value");
   AST_LT_ERR: assert property (lt_eval and (wb_dat_i[LC_BCD] && !bcd_ok(s_r.lt_sv))
      |=> s_r.lt_err && $stable(s_r.lt_pv))
      else $error("decimal error not flagged");

   // Set values change only by software writes
   AST_SV_HOLD: assert property (!wr |=> $stable(s_r.lt_sv) && $stable(s_r.mt_sv))
      else $error("set value changed without a write");
   // Banked time grows by one per tick until it saturates
   AST_BANK: assert property (tick && s_r.lt_acc != ACC_MAX && !wr
      |=> s_r.lt_acc == $past(s_r.lt_acc) + 8'h01)
      else $error("elapsed tick not banked");

   // Multi timer: count, wrap, reset, pause and compare
   AST_MT_INC: assert property (s_r.fsm == ST_MT && s_r.mt_steps != 8'h00
      && s_r.mt_pv != mt_max && !s_r.mt_bcd && !wr
      |=> s_r.mt_pv == $past(s_r.mt_pv) + 16'h0001)
      else $error("multi timer step missed");
   AST_MT_WRAP: assert property (s_r.fsm == ST_MT && s_r.mt_steps != 8'h00
      && s_r.mt_pv == mt_max && !wr
      |=> s_r.mt_pv == 16'h0000 && s_r.mt_ctrl[MT_NFLAG-1:0] == 8'h00)
      else $error("multi timer did not wrap");
   AST_MT_RST: assert property (mt_eval and s_r.mt_ctrl[MT_RST_BIT]
      |=> s_r.mt_pv == 16'h0000 && s_r.mt_ctrl[MT_NFLAG-1:0] == 8'h00
      ##1 s_r.fsm == ST_IDLE)
      else $error("multi timer reset ignored");
   AST_MT_PAUSE: assert property (mt_eval and (!s_r.mt_ctrl[MT_RST_BIT]
      && s_r.mt_ctrl[MT_PAUSE_BIT])
      |=> $stable(s_r.mt_pv) && s_r.fsm == ST_IDLE)
      else $error("paused multi timer changed");
   // Without execution even a set reset bit must leave the words alone
   AST_MT_NOEXEC: assert property (mt_skip
      |=> $stable(s_r.mt_pv) && $stable(s_r.mt_ctrl) && s_r.fsm == ST_IDLE)
      else $error("multi timer acted without execution");
   AST_MT_FLAGS: assert property (s_r.fsm == ST_MT && s_r.mt_steps == 8'h00 && !wr
      && s_r.mt_sv[0] != 16'h0000 && s_r.mt_sv[0] <= s_r.mt_pv && !s_r.mt_bcd
      |=> s_r.mt_ctrl[0])
      else $error("first completion flag not set");
endmodule : lmt_timer
`default_nettype wire

//--- design/lmt_pkg.sv
// Purpose: Shared constants and types for the long and multi-output timer.
// Assumes: 40 MHz clk_i, classic Wishbone with 8-bit byte address.
// Notes: All registers fit in the low 16 bits of a 32-bit word.
package lmt_pkg;
   // Time base
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ / 1000 * TICK_MS;
   // Register byte addresses
   localparam logic [7:0] A_LT_SV_LO = 8'h00;
   localparam logic [7:0] A_LT_SV_HI = 8'h04;
   localparam logic [7:0] A_LT_PV_LO = 8'h08;
   localparam logic [7:0] A_LT_PV_HI = 8'h0c;
   localparam logic [7:0] A_LT_FLAG = 8'h10;
   localparam logic [7:0] A_LT_CMD = 8'h14;
   localparam logic [7:0] A_MT_CTRL = 8'h18;
   localparam logic [7:0] A_MT_PV = 8'h1c;
   localparam logic [7:0] A_MT_SV0 = 8'h20;
   localparam logic [7:0] A_MT_SV7 = 8'h3c;
   localparam logic [7:0] A_MT_CMD = 8'h40;
   // Command and status bit positions
   localparam int LC_INPUT = 0;
   localparam int LC_ILOCK = 1;
   localparam int LC_BCD = 2;
   localparam int MC_EXEC = 0;
   localparam int MC_BCD = 1;
   localparam int ST_ERR = 8;
   localparam int ST_BUSY = 9;
   // Multi-output control word layout
   localparam int MT_RST_BIT = 8;
   localparam int MT_PAUSE_BIT = 9;
   localparam int MT_NFLAG = 8;
   // Value limits
   localparam logic [15:0] MT_MAX_BCD = 16'h9999;
   localparam logic [15:0] MT_MAX_BIN = 16'hffff;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [7:0] ACC_MAX = 8'hff;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LT = 2'b01,
      ST_MT = 2'b10
   } lmt_fsm_t;
   typedef struct packed {
      lmt_fsm_t fsm;
      logic ack;
      logic [31:0] dat;
      logic [21:0] tick_cnt;
      logic [31:0] lt_sv;
      logic [31:0] lt_pv;
      logic lt_flag;
      logic lt_in_prev;
      logic lt_err;
      logic lt_bcd;
      logic [7:0] lt_acc;
      logic [7:0] lt_steps;
      logic [9:0] mt_ctrl;
      logic [15:0] mt_pv;
      logic [7:0][15:0] mt_sv;
      logic mt_err;
      logic mt_bcd;
      logic [7:0] mt_acc;
      logic [7:0] mt_steps;
   } lmt_state_t;
endpackage : lmt_pkg

//--- verif/lmt_scan_master.sv
// Purpose: Stand-in for the control program, which runs one bus cycle at a time.
// Assumes: Classic Wishbone single cycles; the answer is sampled at the rising edge.
// Notes: The bench calls xfer; only the low two byte lanes carry register data.
`timescale 1ns/1ps
`default_nettype none
module lmt_scan_master (
   input wire logic clk_i,
   input wire logic wb_ack_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   // Idle bus from time zero
   initial begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_adr_o <= 8'h00;
      wb_sel_o <= 4'h0;
      wb_dat_o <= 32'h0;
   end

   // One cycle, held until ack is seen; the program touches no timer word mid-run
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'h3;
      wb_dat_o <= wd;
      // No cycle count is assumed here; the bench watchdog cuts a hang
      do @(posedge clk_i); while (wb_ack_i !== 1'b1);
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_dat_o <= ~wd;
   endtask : xfer
endmodule : lmt_scan_master
`default_nettype wire

//--- verif/testbench.sv
// Purpose: Self-checking bench for the long and multi-output timer.
// Assumes: Tick shortened to 20 clocks; one evaluation settles within 260 clocks.
// Notes: Banked tick counts vary, so counting results are checked against ranges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
   import lmt_pkg::*;
   typedef struct packed {logic [31:0] m; logic [31:0] lo; logic [31:0] hi;} lmt_exp_t;
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, seed, sv, g;
   lmt_exp_t q[$];
   lmt_exp_t e;
   int n_fail = 0;
   int comparisons = 0;

   lmt_timer #(.TICK_CYCLES(20)) i_lmt_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   lmt_scan_master i_lmt_scan_master (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_cyc_o(wb_cyc),
      .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
      .wb_dat_o(wb_wdat));

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr_next

   task automatic test_done();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      i_lmt_scan_master.xfer(1'b1, adr, d);
   endtask : wr

   // Note a masked range, then read; the watcher compares when ack shows up
   task automatic chk(input logic [7:0] adr, input logic [31:0] m, lo, hi);
      q.push_back('{m: m, lo: lo, hi: hi});
      i_lmt_scan_master.xfer(1'b0, adr, 32'h0);
   endtask : chk

   task automatic eq(input logic [7:0] adr, input logic [31:0] v);
      chk(adr, 32'hffffffff, v, v);
   endtask : eq

   // Evaluations, then a wait long enough for the longest banked run
   task automatic ev_lt(input logic [2:0] c);
      wr(A_LT_CMD, {29'h0, c});
      repeat (260) @(posedge clk_i);
   endtask : ev_lt

   task automatic ev_mt(input logic [1:0] c);
      wr(A_MT_CMD, {30'h0, c});
      repeat (260) @(posedge clk_i);
   endtask : ev_mt

   task automatic mt_svs(input logic [15:0] a, b, r);
      wr(A_MT_SV0, {16'h0, a});
      wr(A_MT_SV0 + 8'h04, {16'h0, b});
      for (int i = 2; i < 8; i++) wr(A_MT_SV0 + 8'(4 * i), {16'h0, r});
   endtask : mt_svs

   // Read watcher: oldest note against the data sampled with ack
   always @(posedge clk_i) begin
      if (wb_cyc && !wb_we && wb_ack === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         g = wb_rdat & e.m;
         `CHK(((g >= e.lo && g <= e.hi) ? e.lo : g), e.lo)
      end
   end

   // Watchdog, well beyond the expected run of about 6k clocks
   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      test_done();
   end

   initial begin
      seed = 32'h2eaa4614;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // Every register and one unmapped word read zero after reset
      for (int a = 0; a <= 'h44; a += 4) eq(8'(a), 32'h0);
      wr(8'h44, 32'hffff);
      eq(8'h44, 32'h0);
      // Input off reloads a random 32-bit set value into both halves
      seed = lfsr_next(seed);
      sv = seed;
      wr(A_LT_SV_LO, {16'h0, sv[15:0]});
      wr(A_LT_SV_HI, {16'h0, sv[31:16]});
      ev_lt(3'b000);
      eq(A_LT_PV_LO, {16'h0, sv[15:0]});
      eq(A_LT_PV_HI, {16'h0, sv[31:16]});
      eq(A_LT_FLAG, 32'h0);
      // Interlocked evaluation reloads a disturbed value
      wr(A_LT_PV_LO, 32'h1);
      wr(A_LT_FLAG, 32'h1);
      ev_lt(3'b011);
      eq(A_LT_PV_LO, {16'h0, sv[15:0]});
      eq(A_LT_FLAG, 32'h0);
      // Countdown: no movement without evaluation, then down by banked steps
      wr(A_LT_SV_LO, 32'h0100);
      wr(A_LT_SV_HI, 32'h0);
      ev_lt(3'b000);
      ev_lt(3'b001);
      repeat (300) @(posedge clk_i);
      eq(A_LT_PV_LO, 32'h0100);
      ev_lt(3'b001);
      chk(A_LT_PV_LO, 32'hffff, 32'h00c0, 32'h00ff);
      eq(A_LT_FLAG, 32'h0);
      // Timeout, hold, flag forcing and restart by a nonzero value
      wr(A_LT_SV_LO, 32'h0003);
      ev_lt(3'b000);
      ev_lt(3'b001);
      ev_lt(3'b001);
      eq(A_LT_PV_LO, 32'h0);
      eq(A_LT_FLAG, 32'h1);
      ev_lt(3'b001);
      eq(A_LT_FLAG, 32'h1);
      wr(A_LT_FLAG, 32'h0);
      eq(A_LT_FLAG, 32'h0);
      eq(A_LT_PV_LO, 32'h0);
      wr(A_LT_PV_LO, 32'h0005);
      ev_lt(3'b001);
      eq(A_LT_PV_LO, 32'h0);
      eq(A_LT_FLAG, 32'h1);
      // Decimal mode: a bad set value raises the error bit, a good one clears it
      wr(A_LT_SV_LO, 32'h00ab);
      ev_lt(3'b100);
      chk(A_LT_CMD, 32'h100, 32'h100, 32'h100);
      wr(A_LT_SV_LO, 32'h0012);
      ev_lt(3'b100);
      chk(A_LT_CMD, 32'h100, 32'h0, 32'h0);
      // Multi timer: count up and compare against eight set values
      mt_svs(16'h0001, 16'h0002, 16'h9000);
      wr(A_MT_PV, 32'h0020);
      ev_mt(2'b01);
      chk(A_MT_PV, 32'hffff, 32'h0021, 32'h0120);
      eq(A_MT_CTRL, 32'h003);
      mt_svs(16'h0001, 16'h0001, 16'h0001);
      ev_mt(2'b01);
      eq(A_MT_CTRL, 32'h0ff);
      // Pause holds value and flags; clearing it resumes counting
      wr(A_MT_CTRL, 32'h200);
      wr(A_MT_PV, 32'h0040);
      ev_mt(2'b01);
      eq(A_MT_PV, 32'h0040);
      eq(A_MT_CTRL, 32'h200);
      wr(A_MT_CTRL, 32'h0);
      ev_mt(2'b01);
      chk(A_MT_PV, 32'hffff, 32'h0041, 32'h0140);
      // Reset bit ignored without execution, obeyed with it, paused or not
      wr(A_MT_CTRL, 32'h100);
      wr(A_MT_PV, 32'h0077);
      ev_mt(2'b00);
      eq(A_MT_PV, 32'h0077);
      ev_mt(2'b01);
      eq(A_MT_PV, 32'h0);
      eq(A_MT_CTRL, 32'h100);
      wr(A_MT_CTRL, 32'h3ff);
      wr(A_MT_PV, 32'h0055);
      ev_mt(2'b01);
      eq(A_MT_PV, 32'h0);
      eq(A_MT_CTRL, 32'h300);
      // Wrap at the top of each number form clears every flag
      mt_svs(16'h8000, 16'h8000, 16'h8000);
      for (int m = 0; m < 2; m++) begin
         wr(A_MT_CTRL, 32'h0ff);
         wr(A_MT_PV, (m == 0) ? 32'h9999 : 32'hffff);
         ev_mt((m == 0) ? 2'b11 : 2'b01);
         eq(A_MT_CTRL, 32'h0);
         chk(A_MT_PV, 32'hffff, 32'h0, 32'h0300);
      end
      repeat (4) @(posedge clk_i);
      test_done();
   end
endmodule : testbench
`default_nettype wire
